/* core/uart_frame_format_autobaud.sv */
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module uart_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	// fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0]   cnt_reg;
	logic          push;
	logic          pop;

	assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_reg != '0);
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_data_o  = mem_reg[rp_reg];

	always_ff @(posedge mclk_i)
		if (push)
			mem_reg[wp_reg] <= in_data_i;

	always_ff @(posedge mclk_i)
		if (rst_i)
		begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (push)
				wp_reg <= wp_reg + AW'(1);
			if (pop)
				rp_reg <= rp_reg + AW'(1);
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
endmodule

module uart_frame_format_autobaud
	import uart_cfg_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	// register port
	input  wire bus_req_type  bus_i,
	output logic [31:0]       rdata_o,
	// serial line
	input  wire logic         serial_rx_line_i,
	output logic              serial_tx_line_o,
	// measured divisor view
	output logic [15:0]       divisor_o
);
	// =====================================================
	// registers
	mode_type      mode_reg;
	logic [15:0]   div_reg;
	logic [31:0]   rdata_reg;
	logic          ovr_reg;
	logic          frm_reg;
	logic          par_reg;
	logic          wr_mode;
	logic          wr_div;
	logic          wr_tx;
	logic          wr_st;
	logic          rd_rx;
	logic          ab_done;
	logic [15:0]   ab_div;
	logic          fifo_in_valid;
	logic          fifo_in_ready;
	logic [8:0]    fifo_in_data;
	logic          fifo_out_valid;
	logic [8:0]    fifo_out_data;
	logic          stop_err;
	logic          par_err;

	assign wr_mode = bus_i.wr && bus_i.addr == OFS_MODE;
	assign wr_div  = bus_i.wr && bus_i.addr == OFS_DIVISOR;
	assign wr_tx   = bus_i.wr && bus_i.addr == OFS_TX_DATA;
	assign wr_st   = bus_i.wr && bus_i.addr == OFS_STATUS;
	assign rd_rx   = bus_i.rd && bus_i.addr == OFS_RX_DATA;

	// a software write in the same cycle wins over the hardware clear
	always_ff @(posedge mclk_i)
		if (rst_i)
			mode_reg <= mode_type'(MODE_RESET);
		else if (wr_mode)
			mode_reg <= mode_type'(bus_i.wdata[AUTO_BIT:STOP_BIT]);
		else if (ab_done)
			mode_reg.auto_rate_measure_en <= 1'b0;

	always_ff @(posedge mclk_i)
		if (rst_i)
			div_reg <= DIV_RESET;
		else if (ab_done)
			div_reg <= ab_div;
		else if (wr_div)
			div_reg <= bus_i.wdata[15:0];

	// sticky errors: write one to clear, a new event wins
	always_ff @(posedge mclk_i)
		if (rst_i)
		begin
			ovr_reg <= 1'b0;
			frm_reg <= 1'b0;
			par_reg <= 1'b0;
		end
		else
		begin
			ovr_reg <= (fifo_in_valid & ~fifo_in_ready) | (ovr_reg & ~(wr_st & bus_i.wdata[ST_OVERRUN]));
			frm_reg <= stop_err | (frm_reg & ~(wr_st & bus_i.wdata[ST_FRAMING]));
			par_reg <= par_err | (par_reg & ~(wr_st & bus_i.wdata[ST_PARITY]));
		end

	logic [3:0] tx_left_reg;

	always_ff @(posedge mclk_i)
		if (rst_i)
			rdata_reg <= '0;
		else if (bus_i.rd)
			case (bus_i.addr)
				OFS_MODE:    rdata_reg <= {26'h0, mode_reg};
				OFS_DIVISOR: rdata_reg <= {16'h0, div_reg};
				OFS_RX_DATA: rdata_reg <= {23'h0, fifo_out_data & {9{fifo_out_valid}}};
				OFS_STATUS:  rdata_reg <= {27'h0, tx_left_reg != 4'h0, par_reg, frm_reg, ovr_reg, fifo_out_valid};
				default:     rdata_reg <= '0;
			endcase
		else
			rdata_reg <= '0;

	assign rdata_o   = rdata_reg;
	assign divisor_o = div_reg;

	// =====================================================
	// oversampling tick
	logic [15:0] tick_cnt_reg;
	logic        tick;
	logic [3:0]  os_max;
	logic [3:0]  os_half;

	// a divisor lowered below the running count must not wait for a wrap
	assign tick    = (tick_cnt_reg >= div_reg);
	assign os_max  = mode_reg.fast_oversample_sel ? OS_FAST_MAX : OS_STD_MAX;
	assign os_half = mode_reg.fast_oversample_sel ? OS_FAST_HALF : OS_STD_HALF;

	always_ff @(posedge mclk_i)
		if (rst_i || tick || ab_done)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + 16'h1;

	// =====================================================
	// transmitter
	logic [12:0] tx_shift_reg;
	logic [3:0]  tx_os_reg;
	logic [7:0]  tx_byte;
	logic        tx_par;
	logic        tx_bit_end;

	assign tx_byte    = bus_i.wdata[7:0];
	assign tx_par     = (mode_reg.parity_data_sel == PDS_8O) ? ~^tx_byte : ^tx_byte;
	assign tx_bit_end = tick && tx_os_reg == os_max;

	always_ff @(posedge mclk_i)
		if (rst_i)
		begin
			tx_shift_reg <= '1;
			tx_left_reg  <= '0;
			tx_os_reg    <= '0;
		end
		else if (wr_tx && tx_left_reg == 4'h0)
		begin
			tx_os_reg   <= '0;
			tx_left_reg <= LEN_BASE + 4'(mode_reg.parity_data_sel != PDS_8N)
				+ 4'(mode_reg.stop_count_sel);
			case (mode_reg.parity_data_sel)
				PDS_9N:         tx_shift_reg <= {3'h7, bus_i.wdata[8:0], 1'b0};
				PDS_8O, PDS_8E: tx_shift_reg <= {3'h7, tx_par, tx_byte, 1'b0};
				default:        tx_shift_reg <= {4'hf, tx_byte, 1'b0};
			endcase
		end
		else if (tx_left_reg != 4'h0 && tick)
		begin
			tx_os_reg <= tx_bit_end ? 4'h0 : tx_os_reg + 4'h1;
			if (tx_bit_end)
			begin
				tx_shift_reg <= {1'b1, tx_shift_reg[12:1]};
				tx_left_reg  <= tx_left_reg - 4'h1;
			end
		end

	assign serial_tx_line_o = tx_shift_reg[0];

	// =====================================================
	// receiver and rate measurement
	rx_state_type rx_state_reg;
	logic         rx_s1_reg;
	logic         rx_s2_reg;
	logic         rx_prev_reg;
	logic         rx_norm;
	logic         rx_fall;
	logic [3:0]   rx_os_reg;
	logic [3:0]   rx_bits_reg;
	logic [8:0]   rx_shift_reg;
	logic         rx_stop2_reg;
	logic         rx_samp;
	logic         nine;
	logic [23:0]  ab_cnt_reg;
	logic [2:0]   ab_edges_reg;
	logic [23:0]  ab_bit;

	assign rx_norm = rx_s2_reg ^ mode_reg.rx_idle_invert;
	assign rx_fall = rx_prev_reg & ~rx_norm;
	assign rx_samp = tick && rx_os_reg == os_max;
	assign nine    = (mode_reg.parity_data_sel == PDS_9N);

	always_ff @(posedge mclk_i)
		if (rst_i)
		begin
			rx_s1_reg   <= 1'b1;
			rx_s2_reg   <= 1'b1;
			rx_prev_reg <= 1'b1;
		end
		else
		begin
			rx_s1_reg   <= serial_rx_line_i;
			rx_s2_reg   <= rx_s1_reg;
			rx_prev_reg <= rx_norm;
		end

	// sync char spans eight bit times between its first and fifth falling edge
	assign ab_bit  = mode_reg.fast_oversample_sel ? (ab_cnt_reg >> AB_SHIFT_FST) : (ab_cnt_reg >> AB_SHIFT_STD);
	assign ab_div  = (ab_bit[15:0] == 16'h0) ? 16'h0 : ab_bit[15:0] - 16'h1;
	assign ab_done = rx_state_reg == RX_BAUD && rx_fall && ab_edges_reg == AB_LAST_EDGE;

	assign fifo_in_valid = rx_state_reg == RX_STOP && rx_samp && rx_norm && !rx_stop2_reg;
	assign fifo_in_data  = nine ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
	assign stop_err      = rx_state_reg == RX_STOP && rx_samp && !rx_norm;
	assign par_err       = rx_state_reg == RX_PARITY && rx_samp
		&& ((^rx_shift_reg[8:1] ^ rx_norm) != (mode_reg.parity_data_sel == PDS_8O));

	always_ff @(posedge mclk_i)
		if (rst_i)
		begin
			rx_state_reg <= RX_IDLE;
			rx_os_reg    <= '0;
			rx_bits_reg  <= '0;
			rx_shift_reg <= '0;
			rx_stop2_reg <= 1'b0;
			ab_cnt_reg   <= '0;
			ab_edges_reg <= '0;
		end
		else
		begin
			if (tick)
				rx_os_reg <= (rx_samp || (rx_state_reg == RX_START && rx_os_reg == os_half)) ? 4'h0 : rx_os_reg + 4'h1;
			case (rx_state_reg)
				RX_IDLE:
					if (rx_fall)
					begin
						rx_os_reg    <= '0;
						ab_cnt_reg   <= '0;
						ab_edges_reg <= '0;
						rx_state_reg <= mode_reg.auto_rate_measure_en ? RX_BAUD : RX_START;
					end
				RX_BAUD:
				begin
					ab_cnt_reg <= ab_cnt_reg + 24'h1;
					if (rx_fall)
						ab_edges_reg <= ab_edges_reg + 3'h1;
					if (ab_done)
						rx_state_reg <= RX_IDLE;
				end
				RX_START:
					if (tick && rx_os_reg == os_half)
					begin
						rx_bits_reg  <= '0;
						rx_state_reg <= rx_norm ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (rx_samp)
					begin
						rx_shift_reg <= {rx_norm, rx_shift_reg[8:1]};
						rx_bits_reg  <= rx_bits_reg + 4'h1;
						if (rx_bits_reg == (nine ? BITS_9 : BITS_8))
						begin
							rx_stop2_reg <= mode_reg.stop_count_sel;
							rx_state_reg <= (mode_reg.parity_data_sel == PDS_8O || mode_reg.parity_data_sel == PDS_8E)
								? RX_PARITY : RX_STOP;
						end
					end
				RX_PARITY:
					if (rx_samp)
						rx_state_reg <= RX_STOP;
				RX_STOP:
					if (rx_samp)
					begin
						rx_stop2_reg <= 1'b0;
						if (!rx_stop2_reg || !rx_norm)
							rx_state_reg <= RX_IDLE;
					end
				default:
					rx_state_reg <= RX_IDLE;
			endcase
		end

	uart_fifo #(
		.W     (9),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.in_valid_i  (fifo_in_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (fifo_in_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (rd_rx),
		.out_data_o  (fifo_out_data)
	);

	// =====================================================
	// assertions
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	property p_ab_start;
		rx_state_reg == RX_IDLE && mode_reg.auto_rate_measure_en && rx_fall |=> rx_state_reg == RX_BAUD;
	endproperty
	a_ab_start: assert property (p_ab_start) else $error("measurement did not start");

	property p_ab_clear;
		ab_done && !wr_mode |=> !mode_reg.auto_rate_measure_en && rx_state_reg == RX_IDLE;
	endproperty
	a_ab_clear: assert property (p_ab_clear) else $error("auto enable not cleared");

	property p_ab_load;
		ab_done |=> div_reg == $past(ab_div);
	endproperty
	a_ab_load: assert property (p_ab_load) else $error("divisor not loaded");

	property p_idle_level;
		rx_state_reg == RX_IDLE && !mode_reg.auto_rate_measure_en && rx_prev_reg
			&& rx_s2_reg == mode_reg.rx_idle_invert |=> rx_state_reg == RX_START;
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("start not seen");

	property p_os_bound;
		tx_left_reg != 4'h0 |-> tx_os_reg <= os_max;
	endproperty
	a_os_bound: assert property (p_os_bound) else $error("oversample count too high");

	property p_bit_step;
		tx_left_reg != 4'h0 && tx_bit_end |=> tx_left_reg == $past(tx_left_reg) - 4'h1;
	endproperty
	a_bit_step: assert property (p_bit_step) else $error("bit time wrong");

	property p_tx_len;
		wr_tx && tx_left_reg == 4'h0 |=> tx_left_reg == LEN_BASE
			+ 4'($past(mode_reg.parity_data_sel) != PDS_8N) + 4'($past(mode_reg.stop_count_sel));
	endproperty
	a_tx_len: assert property (p_tx_len) else $error("frame length wrong");

	property p_two_stop;
		rx_state_reg == RX_STOP && rx_samp && rx_stop2_reg && rx_norm |=> rx_state_reg == RX_STOP;
	endproperty
	a_two_stop: assert property (p_two_stop) else $error("second stop skipped");

	property p_overrun;
		fifo_in_valid && !fifo_in_ready |=> ovr_reg;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun lost");

	c_ab_done: cover property (ab_done);
	c_rx_push: cover property (fifo_in_valid && fifo_in_ready);
	c_tx_load: cover property (wr_tx && tx_left_reg == 4'h0);
	c_overrun: cover property (fifo_in_valid && !fifo_in_ready);
endmodule

`default_nettype wire

/* core/uart_cfg_pkg.sv */
package uart_cfg_pkg;
	// register map, byte addresses of 32-bit words
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFS_MODE     = 8'h00;
	localparam logic [7:0]  OFS_DIVISOR  = 8'h04;
	localparam logic [7:0]  OFS_TX_DATA  = 8'h08;
	localparam logic [7:0]  OFS_RX_DATA  = 8'h0c;
	localparam logic [7:0]  OFS_STATUS   = 8'h10;
	// serial_mode_control fields
	localparam int          AUTO_BIT     = 5;
	localparam int          INV_BIT      = 4;
	localparam int          FAST_BIT     = 3;
	localparam int          PDS_LSB      = 1;
	localparam int          STOP_BIT     = 0;
	localparam logic [5:0]  MODE_RESET   = 6'h00;
	localparam logic [1:0]  PDS_9N       = 2'h3;
	localparam logic [1:0]  PDS_8O       = 2'h2;
	localparam logic [1:0]  PDS_8E       = 2'h1;
	localparam logic [1:0]  PDS_8N       = 2'h0;
	// status fields
	localparam int          ST_AVAIL     = 0;
	localparam int          ST_OVERRUN   = 1;
	localparam int          ST_FRAMING   = 2;
	localparam int          ST_PARITY    = 3;
	localparam int          ST_TX_BUSY   = 4;
	// timing and framing constants
	localparam logic [15:0] DIV_RESET    = 16'h0040;
	localparam logic [3:0]  OS_FAST_MAX  = 4'h3;
	localparam logic [3:0]  OS_STD_MAX   = 4'hf;
	localparam logic [3:0]  OS_FAST_HALF = 4'h1;
	localparam logic [3:0]  OS_STD_HALF  = 4'h7;
	localparam logic [7:0]  SYNC_CHAR    = 8'h55;
	localparam logic [2:0]  AB_LAST_EDGE = 3'h3;
	localparam int          AB_SHIFT_FST = 5;
	localparam int          AB_SHIFT_STD = 7;
	localparam logic [3:0]  LEN_BASE     = 4'ha;
	localparam logic [3:0]  BITS_8       = 4'h7;
	localparam logic [3:0]  BITS_9       = 4'h8;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_type;

	typedef struct packed {
		logic       auto_rate_measure_en;
		logic       rx_idle_invert;
		logic       fast_oversample_sel;
		logic [1:0] parity_data_sel;
		logic       stop_count_sel;
	} mode_type;

	typedef enum logic [2:0] {
		RX_IDLE   = 3'h0,
		RX_START  = 3'h1,
		RX_DATA   = 3'h3,
		RX_PARITY = 3'h2,
		RX_STOP   = 3'h6,
		RX_BAUD   = 3'h4
	} rx_state_type;
endpackage

/* testbench/serial_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_partner (
	// clock and line side
	input  wire logic mclk_i,
	input  wire logic tx_line_i,
	output logic      rx_line_o
);
	initial
	begin
		rx_line_o = 1'b1;
	end

	// ==========================================
	// remote transmitter, flaw 1 bad parity, 2 low stop
	task automatic send(input logic [8:0] d, input logic [1:0] pds, input logic inv,
		input int per, input int flaw);
		logic q[$];
		int   i;
		q = {1'b1, 1'b0};
		for (i = 0; i < ((pds == 2'h3) ? 9 : 8); i++)
			q.push_back(d[i]);
		if (pds == 2'h1 || pds == 2'h2)
			q.push_back((pds == 2'h1 ? ^d[7:0] : ~^d[7:0]) ^ (flaw == 1));
		q.push_back(flaw != 2);
		q.push_back(1'b1);
		foreach (q[j])
		begin
			rx_line_o <= q[j] ^ inv;
			repeat (per) @(posedge mclk_i);
		end
	endtask

	// ==========================================
	// remote receiver, samples mid-bit
	task automatic recv(input int per, input int nb, input int hasp,
		output logic [8:0] d, output logic p);
		int i;
		d = '0;
		p = 1'b0;
		@(negedge tx_line_i);
		repeat (per / 2) @(posedge mclk_i);
		for (i = 0; i < nb; i++)
		begin
			repeat (per) @(posedge mclk_i);
			d[i] = tx_line_i;
		end
		if (hasp != 0)
		begin
			repeat (per) @(posedge mclk_i);
			p = tx_line_i;
		end
	endtask
endmodule

`default_nettype wire

/* testbench/test_uart_frame_format_autobaud.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
			$display("CHECK FAILED %s exp %h got %h", what, exp, got); \
		if ((got) !== (exp)) \
			num_errors++; \
	end

module test_uart_frame_format_autobaud
	import uart_cfg_pkg::*;
;
	logic        mclk_i;
	logic        rst_i;
	bus_req_type bus_i;
	logic [31:0] rdata_o;
	logic        rx_line;
	logic        tx_line;
	logic [15:0] divisor_o;
	int          num_errors;
	int          comparisons;
	int          cycles;
	int          k;

	uart_frame_format_autobaud #(.FIFO_DEPTH(16)) u_uart_frame_format_autobaud (
		.mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
		.serial_rx_line_i(rx_line), .serial_tx_line_o(tx_line), .divisor_o(divisor_o));
	serial_partner u_serial_partner (.mclk_i(mclk_i), .tx_line_i(tx_line), .rx_line_o(rx_line));

	always #5 mclk_i = ~mclk_i;

	task automatic tally_and_finish();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// hang guard, run needs about 15000 cycles
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end

	// ==========================================
	// register port
	// no module enable to clear here, so no access ever has to skip a cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_i);
		bus_i.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk_i);
		bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_i);
		bus_i.rd <= 1'b0;
		#1 v = rdata_o;
	endtask

	// ==========================================
	// scenarios
	task automatic reset_case();
		logic [31:0] v;
		rd(OFS_MODE, v);
		`CHK("mode reset", 32'h0, v)
		wr(8'h20, 32'h3f);
		rd(8'h20, v);
		`CHK("unmapped", 32'h0, v)
		rd(OFS_DIVISOR, v);
		`CHK("divisor reset", 32'h40, v)
		`CHK("tx idle", 1'b1, tx_line)
	endtask

	task automatic tx_case(input logic [1:0] pds, input logic stp, input logic [8:0] d);
		logic [8:0]  got;
		logic        p;
		logic [31:0] st;
		int          nb;
		int          np;
		int          t0;
		nb = (pds == PDS_9N) ? 9 : 8;
		np = (pds == PDS_8E || pds == PDS_8O) ? 1 : 0;
		wr(OFS_MODE, {26'h0, 3'h0, pds, stp});
		fork
			u_serial_partner.recv(32, nb, np, got, p);
			begin
				t0 = cycles;
				wr(OFS_TX_DATA, {23'h0, d});
				st = 32'h10;
				while (st[ST_TX_BUSY] && cycles - t0 < 2000)
					rd(OFS_STATUS, st);
			end
		join
		`CHK("tx data", (nb == 9) ? d : {1'b0, d[7:0]}, got)
		if (np == 1)
			`CHK("tx parity", (pds == PDS_8E) ? ^d[7:0] : ~^d[7:0], p)
		`CHK("tx frame bits", 2 + nb + np + stp, (cycles - t0 + 16) / 32)
	endtask

	// fast mode bit is 4 ticks of 2 cycles, standard 16
	task automatic rx_case(input logic [5:0] m, input logic [8:0] d, input int per, input int flaw);
		logic [31:0] v;
		u_serial_partner.rx_line_o <= ~m[INV_BIT];
		wr(OFS_MODE, {26'h0, m});
		u_serial_partner.send(d, m[2:1], m[INV_BIT], per, flaw);
		rd(OFS_STATUS, v);
		`CHK("parity flag", flaw == 1, v[ST_PARITY])
		`CHK("framing flag", flaw == 2, v[ST_FRAMING])
		if (flaw != 2)
			rd(OFS_RX_DATA, v);
		if (flaw == 0)
			`CHK("rx data", {23'h0, (m[2:1] == PDS_9N) ? d : {1'b0, d[7:0]}}, v)
		wr(OFS_STATUS, 32'he);
	endtask

	// sync 0x55 spans 8 bit times between first and last falling edge
	task automatic ab_case(input logic fast, input int per, input int nper);
		logic [31:0] v;
		wr(OFS_MODE, {26'h0, 1'b1, 1'b0, fast, 3'h0});
		u_serial_partner.send(9'h055, 2'h0, 1'b0, per, 0);
		rd(OFS_MODE, v);
		`CHK("auto enable cleared", 1'b0, v[AUTO_BIT])
		`CHK("measured divisor", 16'h0002, divisor_o)
		rx_case({2'h0, fast, 3'h0}, 9'h0a3, nper, 0);
		wr(OFS_DIVISOR, 32'h1);
	endtask

	task automatic fifo_case();
		logic [31:0] v;
		int          i;
		// standard oversampling, 8N1, to match the 32-cycle bits
		wr(OFS_MODE, 32'h0);
		for (i = 0; i < 17; i++)
			u_serial_partner.send(9'(i + 'h30), 2'h0, 1'b0, 32, 0);
		rd(OFS_STATUS, v);
		`CHK("overrun", 1'b1, v[ST_OVERRUN])
		for (i = 0; i < 16; i++)
		begin
			rd(OFS_RX_DATA, v);
			`CHK("fifo word", 32'(i + 'h30), v)
		end
		rd(OFS_STATUS, v);
		`CHK("fifo empty", 1'b0, v[ST_AVAIL])
		rd(OFS_RX_DATA, v);
		`CHK("empty read", 32'h0, v)
	endtask

	initial
	begin
		mclk_i = 1'b0;
		rst_i = 1'b1;
		bus_i = '0;
		num_errors = 0;
		comparisons = 0;
		cycles = 0;
		repeat (3) @(posedge mclk_i);
		rst_i <= 1'b0;
		reset_case();
		wr(OFS_DIVISOR, 32'h1);
		for (k = 0; k < 8; k++)
			tx_case(k[2:1], k[0], 9'h1a5 ^ 9'(k));
		rx_case(6'h00, 9'h05a, 32, 0);
		rx_case(6'h14, 9'h03c, 32, 0);
		rx_case(6'h17, 9'h1c3, 32, 0);
		rx_case(6'h0a, 9'h081, 8, 0);
		rx_case(6'h02, 9'h066, 32, 1);
		rx_case(6'h00, 9'h0f0, 32, 2);
		ab_case(1'b0, 52, 48);
		ab_case(1'b1, 13, 12);
		fifo_case();
		tally_and_finish();
	end
endmodule

`default_nettype wire
